// ### hw/er_defines.svh
`ifndef ER_DEFINES_SVH
`define ER_DEFINES_SVH
`define ER_SLOTS          256
`define ER_GROUP_SIZE     16
`define ER_CHANNELS       16
`define ER_VAL_W          32
`define ER_CLK_HZ         50000000
`define ER_LAT_TYP_US     500
`define ER_LAT_MAX_US     5000
`define ER_LAT_MAX_CYC    ((`ER_LAT_MAX_US * (`ER_CLK_HZ / 1000000)))
`define ER_CFG_W          121
`define ER_HOLD_RST       32'h00000000
`endif

// ### hw/er_pkg.sv
package er_pkg;
  typedef enum logic [3:0] {
    EV_NONE, EV_WATCHDOG, EV_CNT_GE, EV_CNT_LE, EV_QUAD_GE, EV_QUAD_LE,
    EV_FREQ_GE, EV_FREQ_LE, EV_TON_GE, EV_TOFF_GE, EV_PON_GE, EV_POFF_GE,
    EV_PERIOD_GE, EV_PATTERN, EV_ANA_GE, EV_ANA_LE
  } event_t;
  typedef enum logic [4:0] {
    RX_NONE, RX_EN_SCAN, RX_DIS_SCAN, RX_DIS_ALL, RX_SET_PATTERN,
    RX_PULSE_ON, RX_PULSE_OFF, RX_CNT_START, RX_CNT_STOP, RX_CNT_CLEAR,
    RX_QUAD_CLEAR, RX_HOLD, RX_LOOP_ON, RX_LOOP_OFF, RX_LOOP_SETPT,
    RX_AOUT_SET, RX_AOUT_RAMP
  } react_t;
  // Measurement source selector; analog views share the same index space
  typedef enum logic [3:0] {
    SRC_CNT, SRC_QUAD, SRC_FREQ, SRC_TON, SRC_TOFF, SRC_PON, SRC_POFF,
    SRC_PERIOD, SRC_AIN, SRC_AIN_AVG, SRC_AIN_PEAK, SRC_AIN_LOW,
    SRC_AIN_TOT, SRC_AOUT
  } source_t;
  typedef struct packed {
    event_t        ev;
    source_t       src;
    logic [31:0]   limit;
    logic [15:0]   mustOn;
    logic [15:0]   mustOff;
    react_t        rx;
    logic [7:0]    target;
    logic [31:0]   rxValue;
    logic          intrEn;
    logic [2:0]    spare;
  } slot_cfg_t;
  typedef struct packed {
    logic [7:0]  slot;
    react_t      rx;
    logic [7:0]  channel;
    logic [31:0] value;
  } action_t;
endpackage : er_pkg

// ### hw/er_slot_mem.sv
`timescale 1ns/10ps
module er_slot_mem #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 256,
  parameter int AW    = 8
) (
  input  wire logic             clk_sys,
  input  wire logic             ce,
  input  wire logic             we,
  input  wire logic [AW-1:0]    wrAddr,
  input  wire logic [WIDTH-1:0] wrData,
  input  wire logic [AW-1:0]    rdAddr,
  output logic      [WIDTH-1:0] rdData
);
  // Contents are volatile: power loss drops all slot definitions
  logic [WIDTH-1:0] store [DEPTH];
  if (DEPTH > (1 << AW)) begin : g_bad_depth
    $error("er_slot_mem depth exceeds address range");
  end
  always_ff @(posedge clk_sys) begin
    if (ce && we) begin
      store[wrAddr] <= wrData;
    end
  end
  always_ff @(posedge clk_sys) begin
    if (ce) begin
      rdData <= store[rdAddr];
    end
  end
endmodule : er_slot_mem

// ### hw/io_event_reaction_engine.sv
`timescale 1ns/10ps
`include "er_defines.svh"
module io_event_reaction_engine
  import er_pkg::*;
#(
  parameter int SLOTS   = `ER_SLOTS,
  parameter int GROUP   = `ER_GROUP_SIZE,
  parameter int WD_BITS = 32
) (
  input  wire logic                clk_sys,
  input  wire logic                rst,
  input  wire logic                ce,
  input  wire logic                cfgWrite,
  input  wire logic [7:0]          cfgSlot,
  input  wire slot_cfg_t           cfgData,
  input  wire logic                scanEnCmd,
  input  wire logic                scanDisCmd,
  input  wire logic                scanAllEnCmd,
  input  wire logic                scanAllDisCmd,
  input  wire logic                groupEnCmd,
  input  wire logic                groupDisCmd,
  input  wire logic [7:0]          cmdSlot,
  input  wire logic                latchClrCmd,
  input  wire logic                latchClrAllCmd,
  input  wire logic                intrClrCmd,
  input  wire logic                intrEnCmd,
  input  wire logic                intrDisCmd,
  input  wire logic                commSeen,
  input  wire logic [WD_BITS-1:0]  wdTimeout,
  input  wire logic [15:0]         chanIn,
  input  wire logic [32*14-1:0]    measIn,
  input  wire logic [7:0]          holdSel,
  output logic [31:0]              holdData,
  output logic [SLOTS-1:0]         latchOut,
  output logic [SLOTS-1:0]         scanEnOut,
  output logic                     intrLine,
  output logic                     wdExpired,
  output logic                     actionValid,
  output action_t                  action,
  output logic                     passDone
);
  if (SLOTS != 256 || GROUP != 16) begin : g_bad_slots
    $error("Slot count and group size are fixed by the address layout");
  end
  if (WD_BITS < 1) begin : g_bad_wd
    $error("Watchdog width must be positive");
  end

  logic [15:0]        chanSync1;
  logic [15:0]        chanSync2;
  logic [15:0]        patternOut;
  logic [SLOTS-1:0]   prevCond;
  logic [SLOTS-1:0]   intrMask;
  logic               holdWr;
  logic [31:0]        holdRd;
  logic [WD_BITS-1:0] wdCount;
  logic [7:0]         scanIdx;
  logic [7:0]         evalIdx;
  logic               evalValid;
  logic               evalEn;
  slot_cfg_t          cur;
  logic               cond;
  logic               fire;
  logic [31:0]        selVal;

  // External channel levels arrive asynchronously
  always_ff @(posedge clk_sys) begin
    if (ce) begin
      chanSync1 <= chanIn;
      chanSync2 <= chanSync1;
    end
  end

  // Slot table is volatile working storage
  er_slot_mem #(.WIDTH($bits(slot_cfg_t)), .DEPTH(SLOTS), .AW(8)) cfgMem (
    .clk_sys (clk_sys),
    .ce      (ce),
    .we      (cfgWrite),
    .wrAddr  (cfgSlot),
    .wrData  (cfgData),
    .rdAddr  (scanIdx),
    .rdData  (cur)
  );

  function automatic logic [31:0] pick(input logic [32*14-1:0] m,
                                       input source_t s);
    pick = m[32*int'(s) +: 32];
  endfunction : pick

  // Channel state: inputs pins merged with pattern outputs we drive
  logic [15:0] chanNow;
  assign chanNow = chanSync2 | patternOut;
  assign selVal  = pick(measIn, cur.src);

  always_comb begin
    case (cur.ev)
      EV_WATCHDOG: cond = wdExpired;
      EV_CNT_GE, EV_QUAD_GE, EV_FREQ_GE,
      EV_ANA_GE:   cond = selVal >= cur.limit;
      EV_CNT_LE, EV_QUAD_LE, EV_FREQ_LE,
      EV_ANA_LE:   cond = selVal <= cur.limit;
      EV_TON_GE, EV_TOFF_GE, EV_PON_GE, EV_POFF_GE,
      EV_PERIOD_GE: cond = selVal >= cur.limit;
      EV_PATTERN:  cond = ((chanNow & cur.mustOn) == cur.mustOn) &&
                          ((chanNow & cur.mustOff) == 16'h0000);
      default:     cond = 1'b0;
    endcase
  end

  // Edge against stored previous value gives one firing per rising edge
  assign fire = evalValid && evalEn && cond && !prevCond[evalIdx];

  // One slot per cycle: 256 slots take ~5.1 us, far inside 5 ms
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      scanIdx   <= 8'h00;
      evalIdx   <= 8'h00;
      evalValid <= 1'b0;
      passDone  <= 1'b0;
    end else if (ce) begin
      scanIdx   <= scanIdx + 8'h01;
      evalIdx   <= scanIdx;
      evalValid <= 1'b1;
      passDone  <= (scanIdx == 8'hFF);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      evalEn <= 1'b0;
    end else if (ce) begin
      evalEn <= scanEnOut[scanIdx];
    end
  end

  // Scan enables; the next slot's enable is already sampled, so reactions take effect from the slot after next
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      scanEnOut <= '0;
      prevCond  <= '0;
    end else if (ce) begin
      if (evalValid && evalEn) prevCond[evalIdx] <= cond;
      if (scanAllDisCmd) scanEnOut <= '0;
      if (scanAllEnCmd) begin
        scanEnOut <= '1;
        prevCond  <= '0;
      end
      if (groupDisCmd) scanEnOut[cmdSlot[7:4]*16 +: 16] <= 16'h0000;
      if (groupEnCmd) begin
        scanEnOut[cmdSlot[7:4]*16 +: 16] <= 16'hFFFF;
        prevCond[cmdSlot[7:4]*16 +: 16]  <= 16'h0000;
      end
      if (scanDisCmd) scanEnOut[cmdSlot] <= 1'b0;
      if (scanEnCmd) begin
        scanEnOut[cmdSlot] <= 1'b1;
        prevCond[cmdSlot]  <= 1'b0;
      end
      if (fire) begin
        case (cur.rx)
          RX_EN_SCAN: begin
            scanEnOut[cur.target] <= 1'b1;
            prevCond[cur.target]  <= 1'b0;
          end
          RX_DIS_SCAN: scanEnOut[cur.target] <= 1'b0;
          RX_DIS_ALL:  scanEnOut <= '0;
          default: ;
        endcase
      end
    end
  end

  // Latches: a firing in the same cycle as a clear keeps the latch set
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      latchOut <= '0;
    end else if (ce) begin
      if (latchClrAllCmd) latchOut <= '0;
      if (latchClrCmd) latchOut[cmdSlot] <= 1'b0;
      if (fire) latchOut[evalIdx] <= 1'b1;
    end
  end

  // Hold buffers share one memory; readout costs a second cycle
  assign holdWr = fire && cur.rx == RX_HOLD;
  er_slot_mem #(.WIDTH(32), .DEPTH(SLOTS), .AW(8)) holdMem (
    .clk_sys (clk_sys),
    .ce      (ce),
    .we      (holdWr),
    .wrAddr  (evalIdx),
    .wrData  (selVal),
    .rdAddr  (holdSel),
    .rdData  (holdRd)
  );

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      holdData <= `ER_HOLD_RST;
    end else if (ce) begin
      holdData <= holdRd;
    end
  end

  // Interrupt enables per slot, loaded with configuration
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      intrMask <= '0;
    end else if (ce) begin
      if (cfgWrite) intrMask[cfgSlot] <= cfgData.intrEn;
      if (intrDisCmd) intrMask[cmdSlot] <= 1'b0;
      if (intrEnCmd) intrMask[cmdSlot] <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      intrLine <= 1'b0;
    end else if (ce) begin
      if (fire && intrMask[evalIdx]) intrLine <= 1'b1;
      else if (intrClrCmd) intrLine <= 1'b0;
    end
  end

  // Watchdog counts cycles of silence; zero timeout disables it
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      wdCount   <= '0;
      wdExpired <= 1'b0;
    end else if (ce) begin
      if (commSeen) begin
        wdCount   <= '0;
        wdExpired <= 1'b0;
      end else if (wdTimeout != '0 && wdCount > wdTimeout) begin
        wdExpired <= 1'b1;
      end else begin
        wdCount <= wdCount + WD_BITS'(1);
      end
    end
  end

  // Pattern outputs are kept locally so later slots see them
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      patternOut <= 16'h0000;
    end else if (ce && fire && cur.rx == RX_SET_PATTERN) begin
      patternOut <= (patternOut | cur.mustOn) & ~cur.mustOff;
    end
  end

  // Every reaction but RX_NONE, local ones included, goes out as a one-cycle command to the I/O functions
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      actionValid <= 1'b0;
      action      <= '0;
    end else if (ce) begin
      actionValid <= fire && cur.rx != RX_NONE;
      action.slot    <= evalIdx;
      action.rx      <= cur.rx;
      action.channel <= cur.target;
      action.value   <= (cur.rx == RX_SET_PATTERN) ?
                        {cur.mustOff, cur.mustOn} : cur.rxValue;
    end
  end

  a_once_per_edge: assert property (@(posedge clk_sys) disable iff (rst)
    ce && fire |=> ce |-> prevCond[$past(evalIdx)])
    else $error("prev condition not stored after firing");
  a_latch_sets: assert property (@(posedge clk_sys) disable iff (rst)
    ce && fire |=> latchOut[$past(evalIdx)])
    else $error("latch not set on firing");
  a_latch_holds: assert property (@(posedge clk_sys) disable iff (rst)
    latchOut[evalIdx] && !latchClrAllCmd
    && !(latchClrCmd && cmdSlot == evalIdx)
    |=> latchOut[$past(evalIdx)])
    else $error("latch dropped without clear");
  a_pattern_eval: assert property (@(posedge clk_sys) disable iff (rst)
    evalValid && cur.ev == EV_PATTERN && (chanNow & cur.mustOff) != 0
    |-> !cond)
    else $error("pattern true with must-off channel on");
  a_intr_raise: assert property (@(posedge clk_sys) disable iff (rst)
    ce && fire && intrMask[evalIdx] |=> intrLine)
    else $error("interrupt not raised");
  a_dis_all: assert property (@(posedge clk_sys) disable iff (rst)
    ce && scanAllDisCmd && !scanAllEnCmd && !groupEnCmd && !scanEnCmd
    && !fire |=> scanEnOut == '0)
    else $error("disable all failed");
  a_scan_order: assert property (@(posedge clk_sys) disable iff (rst)
    ce && evalValid ##1 ce |-> evalIdx == $past(evalIdx) + 8'h01)
    else $error("slots not scanned in order");
  a_wd_event: assert property (@(posedge clk_sys) disable iff (rst)
    ce && commSeen |=> !wdExpired)
    else $error("watchdog not cleared by communication");
  a_pass_time: assert property (@(posedge clk_sys) disable iff (rst)
    ce && passDone ##1 ce [*8] |-> !passDone)
    else $error("pass end too frequent");
  c_fire: cover property (@(posedge clk_sys) fire);
  c_hold: cover property (@(posedge clk_sys) fire && cur.rx == RX_HOLD);
  c_wd: cover property (@(posedge clk_sys) $rose(wdExpired));
endmodule : io_event_reaction_engine

// ### verification/host_poll_model.sv
`timescale 1ns/10ps
module host_poll_model (
  input  wire logic        clk_sys,
  input  wire logic        active,
  output logic             commSeen,
  output logic [31:0]      wdTimeout
);
  logic [3:0] tick = 4'h0;
  // Poll gap of 16 cycles stays well inside the timeout
  assign wdTimeout = 32'h00000064;
  initial commSeen = 1'b0;
  always @(negedge clk_sys) begin
    tick <= tick + 4'h1;
    commSeen <= active && (tick == 4'hF);
  end
endmodule : host_poll_model

// ### verification/io_event_reaction_engine_tb_top.sv
`timescale 1ns/10ps
module io_event_reaction_engine_tb_top;
  import er_pkg::*;
  logic clk_sys = 1'b0, rst = 1'b1, ce = 1'b1, cfgWrite = 1'b0;
  logic scanEnCmd = 1'b0, scanDisCmd = 1'b0, scanAllEnCmd = 1'b0;
  logic scanAllDisCmd = 1'b0, groupEnCmd = 1'b0, groupDisCmd = 1'b0;
  logic latchClrCmd = 1'b0, latchClrAllCmd = 1'b0, intrClrCmd = 1'b0;
  logic intrEnCmd = 1'b0, intrDisCmd = 1'b0, polling = 1'b1;
  logic [7:0] cfgSlot = 8'h00, cmdSlot = 8'h00, holdSel = 8'h00;
  logic [15:0] chanIn = 16'h0000;
  logic [32*14-1:0] measIn = '0;
  logic [31:0] wdTimeout, holdData, meas, lim;
  logic [255:0] latchOut, scanEnOut;
  logic commSeen, intrLine, wdExpired, actionValid, passDone;
  slot_cfg_t cfgData = '0, c;
  action_t action;
  action_t q[$];
  int n_fail = 0, compares = 0, pgap = 0;
  event_t evs[17] = '{EV_CNT_GE, EV_CNT_LE, EV_QUAD_GE, EV_QUAD_LE,
    EV_FREQ_GE, EV_FREQ_LE, EV_TON_GE, EV_TOFF_GE, EV_PON_GE, EV_POFF_GE,
    EV_PERIOD_GE, EV_ANA_GE, EV_ANA_LE, EV_ANA_GE, EV_ANA_LE, EV_ANA_GE,
    EV_ANA_LE};
  source_t srcs[17] = '{SRC_CNT, SRC_CNT, SRC_QUAD, SRC_QUAD, SRC_FREQ,
    SRC_FREQ, SRC_TON, SRC_TOFF, SRC_PON, SRC_POFF, SRC_PERIOD, SRC_AIN,
    SRC_AIN_AVG, SRC_AIN_PEAK, SRC_AIN_LOW, SRC_AIN_TOT, SRC_AOUT};

  always #10 clk_sys = ~clk_sys;

  host_poll_model HOST (.clk_sys(clk_sys), .active(polling),
    .commSeen(commSeen), .wdTimeout(wdTimeout));

  io_event_reaction_engine DUT (.clk_sys(clk_sys), .rst(rst), .ce(ce),
    .cfgWrite(cfgWrite), .cfgSlot(cfgSlot), .cfgData(cfgData),
    .scanEnCmd(scanEnCmd), .scanDisCmd(scanDisCmd),
    .scanAllEnCmd(scanAllEnCmd), .scanAllDisCmd(scanAllDisCmd),
    .groupEnCmd(groupEnCmd), .groupDisCmd(groupDisCmd), .cmdSlot(cmdSlot),
    .latchClrCmd(latchClrCmd), .latchClrAllCmd(latchClrAllCmd),
    .intrClrCmd(intrClrCmd), .intrEnCmd(intrEnCmd),
    .intrDisCmd(intrDisCmd), .commSeen(commSeen), .wdTimeout(wdTimeout),
    .chanIn(chanIn), .measIn(measIn), .holdSel(holdSel),
    .holdData(holdData), .latchOut(latchOut), .scanEnOut(scanEnOut),
    .intrLine(intrLine), .wdExpired(wdExpired),
    .actionValid(actionValid), .action(action), .passDone(passDone));

  task automatic conclude;
    $display("compares %0d mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : conclude

  task automatic chk_val(input logic [255:0] g, input logic [255:0] e);
    compares++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] %0t got %0h exp %0h", $time, g, e);
    end
  endtask : chk_val

  task automatic chk_act(input action_t g, input action_t e);
    compares++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] %0t got %0h exp %0h", $time, g, e);
    end
  endtask : chk_act

  // Two edges per pulse so one strobe never toggles twice in a step
  task automatic pulse(ref logic s);
    s = 1'b1;
    @(negedge clk_sys);
    s = 1'b0;
    @(negedge clk_sys);
  endtask : pulse

  task automatic cmd(input logic [7:0] sl, ref logic s);
    cmdSlot = sl;
    pulse(s);
  endtask : cmd

  task automatic wr(input logic [7:0] sl);
    cfgSlot = sl;
    cfgData = c;
    pulse(cfgWrite);
  endtask : wr

  task automatic wt(input int n);
    repeat (n) @(negedge clk_sys);
  endtask : wt

  task automatic expect_act(input logic [7:0] sl, input react_t rx,
                            input logic [7:0] ch, input logic [31:0] v);
    action_t a;
    a = '0;
    a.slot = sl;
    a.rx = rx;
    a.channel = ch;
    a.value = v;
    q.push_back(a);
  endtask : expect_act

  // Bounded wait; the full pass is 256 cycles
  task automatic drain;
    for (int k = 0; k < 700 && q.size() != 0; k++) @(negedge clk_sys);
    chk_val(q.size(), 0);
    q.delete();
  endtask : drain

  // Outputs are settled at the falling edge
  always @(negedge clk_sys) begin
    if (actionValid === 1'b1) begin
      if (q.size() == 0) chk_act(action, '1);
      else chk_act(action, q.pop_front());
    end
    if (passDone === 1'b1) begin
      if (pgap != 0) chk_val(pgap, 256);
      pgap <= 1;
    end else if (pgap != 0) pgap <= pgap + 1;
  end

  initial begin
    repeat (80000) @(posedge clk_sys);
    n_fail++;
    conclude();
  end

  initial begin
    void'($urandom(34182));
    wt(20);
    rst = 1'b0;
    wt(2);
    chk_val(latchOut, 0);
    chk_val(scanEnOut, 0);
    chk_val(intrLine, 0);
    c = '0;
    for (int i = 0; i < 256; i++) wr(i[7:0]);
    pulse(scanAllEnCmd);
    chk_val(scanEnOut, {256{1'b1}});
    pulse(scanAllDisCmd);
    cmd(8'h25, groupEnCmd);
    chk_val(scanEnOut, 256'hFFFF << 32);
    cmd(8'h2A, groupDisCmd);
    chk_val(scanEnOut, 0);
    $display("test scan groups done");
    c.ev = EV_PATTERN; c.mustOn = 16'h0005; c.mustOff = 16'h0002;
    c.rx = RX_HOLD; c.src = SRC_CNT; c.target = 8'h07; c.intrEn = 1'b1;
    meas = $urandom;
    measIn = {14{meas}};
    wr(8'h03);
    cmd(8'h03, intrEnCmd);
    cmd(8'h03, scanEnCmd);
    chanIn = 16'h0007;
    wt(600);
    expect_act(8'h03, RX_HOLD, 8'h07, 32'h00000000);
    chanIn = 16'h0005;
    drain();
    wt(600);
    holdSel = 8'h03;
    wt(2);
    chk_val(holdData, meas);
    chk_val({latchOut[3], intrLine}, 2'h3);
    cmd(8'h04, latchClrCmd);
    chk_val(latchOut[3], 1);
    cmd(8'h03, latchClrCmd);
    chk_val(latchOut[3], 0);
    cmd(8'h03, intrDisCmd);
    pulse(intrClrCmd);
    chk_val(intrLine, 0);
    chanIn = 16'h0000;
    wt(600);
    expect_act(8'h03, RX_HOLD, 8'h07, 32'h00000000);
    chanIn = 16'h0005;
    drain();
    chk_val({latchOut[3], intrLine}, 2'h2);
    pulse(latchClrAllCmd);
    chk_val(latchOut, 0);
    cmd(8'h03, scanDisCmd);
    chanIn = 16'h0000;
    $display("test pattern done");
    for (int i = 0; i < 17; i++) begin
      lim = $urandom_range(32'h7FFFFFF0, 32'h00000001);
      c = '0; c.ev = evs[i]; c.src = srcs[i]; c.limit = lim;
      c.rx = react_t'(4 + i % 13); c.target = i[7:0];
      c.rxValue = $urandom;
      c.mustOn = $urandom;
      if (c.ev inside {EV_CNT_LE, EV_QUAD_LE, EV_FREQ_LE, EV_ANA_LE})
        measIn = {14{lim + 32'h00000001}};
      else measIn = {14{lim - 32'h00000001}};
      cmd(8'h05, scanDisCmd);
      wr(8'h05);
      cmd(8'h05, scanEnCmd);
      wt(600);
      expect_act(8'h05, c.rx, i[7:0], (c.rx == RX_SET_PATTERN) ?
                 {c.mustOff, c.mustOn} : c.rxValue);
      measIn = {14{lim}};
      drain();
      chk_val(latchOut[5], 1);
      if (c.rx == RX_HOLD) begin
        holdSel = 8'h05;
        wt(2);
        chk_val(holdData, lim);
      end
      cmd(8'h05, latchClrCmd);
      chk_val(intrLine, 0);
    end
    cmd(8'h05, scanDisCmd);
    $display("test limits done");
    c = '0; c.ev = EV_CNT_GE; c.src = SRC_CNT; c.rx = RX_EN_SCAN;
    c.target = 8'h0C;
    wr(8'h09);
    c.rx = RX_DIS_ALL; c.target = 8'h00;
    wr(8'h0C);
    expect_act(8'h09, RX_EN_SCAN, 8'h0C, 32'h00000000);
    expect_act(8'h0C, RX_DIS_ALL, 8'h00, 32'h00000000);
    cmd(8'h09, scanEnCmd);
    drain();
    chk_val(scanEnOut, 0);
    $display("test chaining done");
    c = '0; c.ev = EV_WATCHDOG; c.rx = RX_CNT_CLEAR; c.intrEn = 1'b1;
    wr(8'h07);
    cmd(8'h07, scanEnCmd);
    wt(600);
    expect_act(8'h07, RX_CNT_CLEAR, 8'h00, 32'h00000000);
    polling = 1'b0;
    drain();
    chk_val({wdExpired, intrLine}, 2'h3);
    polling = 1'b1;
    $display("test watchdog done");
    conclude();
  end
endmodule : io_event_reaction_engine_tb_top
